//--- shared/hldrc_regs.svh
`ifndef HLDRC_REGS_SVH
`define HLDRC_REGS_SVH
// Behaviour
// [RL1] Software powers down capture converter and headphone path before detection.
// [RL2] Software mutes both analog outputs before detection.
// [RL3] Software clears the playback high-pass enable before detection.
// [RL4] Software sets latch-to-supply, bias 00 and adaptive power 100 first.
// [RL5] Software sets analog ramp rate 0111 and digital ramp rate 0001 first.
// [RL6] Software restores ramp rates, adaptive power and high-pass afterwards.
// [RL7] Plug event with load detect enabled starts resistance and capacitance measurement.
// [RL8] Detection drives a 24 kHz tone on left output, senses selected pin.
// [RL9] Resistance code: 00 is 15 ohm, 01 is 30 ohm, 10 is 3 kohm.
// [RL10] Below 300 ohm assume low capacitance, above it measure capacitance.
// [RL11] At sequence end set done flag and report capacitance low or high.
// [RL12] Measure left channel only and apply the result to both channels.
// [RL13] Software powers headphone path down around compensation changes.
// [RL14] Slow start 111 steps volumes through every setting, whole Fs waits.
// [RL15] Step wait comes from ramp rate fields, between 1 and 72 Fs.
// [RL16] With ramping off a volume change applies on the next edge.
// [RL17] Adaptive power 001..100 fixes rails at 2.5 V, PUMP_INPUT_SUPPLY, PUMP_INPUT_SUPPLY/2, PUMP_INPUT_SUPPLY/3.
// [RL18] Adaptive power 111 raises rails when clipping, else requests lower rails.
// [RL19] Adaptive clip thresholds follow the detected load.
// [RL20] Rail step upward takes effect on the next pump flying clock.
// [RL21] Rail step downward waits 5.5 s of hysteresis.
// [RL22] Renewed higher demand restarts the downward hysteresis timer.

// ----------------------------------------
// Timing
// ----------------------------------------
`define HLDRC_CLK_HZ 32'h00989680
`define HLDRC_TONE_HZ 32'h00005dc0
`define HLDRC_MEAS_TONES 32'h00000020
`define HLDRC_HYST_MS 32'h0000157c
`define HLDRC_MS_DIV 32'h000003e8

// ----------------------------------------
// Encodings
// ----------------------------------------
`define HLDRC_RES_15 2'h0
`define HLDRC_RES_30 2'h1
`define HLDRC_RES_3K 2'h2
`define HLDRC_SLOW_ON 3'h7
`define HLDRC_PWR_FIX0 3'h1
`define HLDRC_PWR_FIX1 3'h2
`define HLDRC_PWR_FIX2 3'h3
`define HLDRC_PWR_FIX3 3'h4
`define HLDRC_PWR_ADAPT 3'h7
`define HLDRC_RAMP_MUL 7'h05
`define HLDRC_RAMP_SUB 7'h03

// ----------------------------------------
// Clip thresholds, attenuation in dB below full scale
// ----------------------------------------
`define HLDRC_T15L_0 8'h08
`define HLDRC_T15L_1 8'h0e
`define HLDRC_T15L_2 8'h14
`define HLDRC_T15H_0 8'h09
`define HLDRC_T15H_1 8'h0e
`define HLDRC_T15H_2 8'h13
`define HLDRC_T30_0 8'h04
`define HLDRC_T30_1 8'h0b
`define HLDRC_T30_2 8'h10
`define HLDRC_T3K_0 8'h01
`define HLDRC_T3K_1 8'h08
`define HLDRC_T3K_2 8'h0d
`endif

//--- shared/hldrc_pkg.sv
package hldrc_pkg;
   typedef enum logic [1:0] {
      HLDRC_IDLE = 2'b00,
      HLDRC_RES = 2'b01,
      HLDRC_CAP = 2'b10
   } hldrc_state_t;

   // Rail level 0 is the highest rail, 3 the lowest
   typedef enum logic [1:0] {
      HLDRC_RAIL_2V5 = 2'b00,
      HLDRC_RAIL_VCP = 2'b01,
      HLDRC_RAIL_VCP2 = 2'b10,
      HLDRC_RAIL_VCP3 = 2'b11
   } hldrc_rail_t;
endpackage : hldrc_pkg

//--- rtl/hldrc_ramp.sv
`include "hldrc_regs.svh"
module hldrc_ramp #(
   parameter int VW = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic fs_tick,
   input wire logic ramp_enable,
   input wire logic [3:0] rate,
   input wire logic [VW-1:0] target,
   output logic [VW-1:0] level
);
   logic [6:0] wait_fs;
   logic [6:0] cnt_ff;
   logic [VW-1:0] level_ff;

   // Wait in Fs periods: code 0 gives 1, code 15 gives 72
   assign wait_fs = (rate == 4'h0) ? 7'h01 :
      ({3'h0, rate} * `HLDRC_RAMP_MUL) - `HLDRC_RAMP_SUB; // RL15
   assign level = level_ff;

   always_ff @(posedge clock)
   begin
      if (reset || !ramp_enable || level_ff == target)
         cnt_ff <= 7'h00;
      else if (fs_tick)
         cnt_ff <= (cnt_ff + 7'h01 >= wait_fs) ? 7'h00 : cnt_ff + 7'h01;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         level_ff <= '0;
      else if (!ramp_enable)
         level_ff <= target; // RL16
      else if (fs_tick && level_ff != target && cnt_ff + 7'h01 >= wait_fs)
      begin
         if (level_ff < target) // RL14
            level_ff <= level_ff + 1'b1;
         else
            level_ff <= level_ff - 1'b1;
      end
   end

   ramp_immediate_a: assert property (@(posedge clock) disable iff (reset)
      !ramp_enable |=> level_ff == $past(target)) // RL16
      else $error("volume not applied at once");
   ramp_single_a: assert property (@(posedge clock) disable iff (reset)
      ramp_enable && $past(ramp_enable) && level_ff != $past(level_ff) |->
      (level_ff == $past(level_ff) + 1'b1 || level_ff == $past(level_ff) - 1'b1)
      && $past(fs_tick)) // RL14
      else $error("ramp skipped a step");
endmodule : hldrc_ramp

//--- rtl/hldrc_top.sv
`include "hldrc_regs.svh"
module hldrc_top #(
   parameter int VW = 8,
   parameter int MEAS_CYCLES = `HLDRC_MEAS_TONES *
      (`HLDRC_CLK_HZ / `HLDRC_TONE_HZ),
   parameter int HYST_CYCLES = `HLDRC_HYST_MS *
      (`HLDRC_CLK_HZ / `HLDRC_MS_DIV)
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic fs_tick,
   input wire logic pump_flying_tick,
   input wire logic plug_detect_pin,
   input wire logic res_above_mid_pin,
   input wire logic res_above_high_pin,
   input wire logic cap_high_pin,
   input wire logic load_detect_enable,
   input wire logic china_headset,
   input wire logic [2:0] slow_start_select,
   input wire logic [3:0] digital_ramp_rate,
   input wire logic [3:0] analog_ramp_rate,
   input wire logic [VW-1:0] playback_volume_target,
   input wire logic [VW-1:0] headphone_volume_target,
   input wire logic [7:0] signal_attenuation,
   input wire logic [2:0] adaptive_power_select,
   output logic headphone_out_left,
   output logic sense_fourth_select,
   output logic measure_active,
   output logic [1:0] load_resistance_status,
   output logic load_capacitance_status,
   output logic load_detect_done,
   output logic [VW-1:0] playback_volume,
   output logic [VW-1:0] headphone_volume,
   output logic [1:0] rail_level
);
   localparam int TONE_HALF = `HLDRC_CLK_HZ / (2 * `HLDRC_TONE_HZ);
   localparam int NS = 4;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] sync1_ff;
   logic [NS-1:0] sync2_ff;
   logic plug_prev_ff;
   logic plug_rise;

   assign pin_raw = {cap_high_pin, res_above_high_pin, res_above_mid_pin,
      plug_detect_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++)
      begin : g_sync
         always_ff @(posedge clock)
         begin
            if (reset)
            begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end
            else
            begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (reset)
         plug_prev_ff <= 1'b0;
      else
         plug_prev_ff <= sync2_ff[0];
   end
   assign plug_rise = sync2_ff[0] && !plug_prev_ff;

   // ----------------------------------------
   // Load detection sequence
   // ----------------------------------------
   hldrc_pkg::hldrc_state_t state_ff;
   logic [31:0] meas_cnt_ff;
   logic meas_end;
   logic [1:0] res_code;
   logic [1:0] res_ff;
   logic cap_ff;
   logic done_ff;
   logic [31:0] tone_cnt_ff;
   logic tone_ff;
   logic sense_ff;

   assign meas_end = meas_cnt_ff == 32'(MEAS_CYCLES - 1);
   // Sense results come from the left channel only
   assign res_code = sync2_ff[2] ? `HLDRC_RES_3K :
      (sync2_ff[1] ? `HLDRC_RES_30 : `HLDRC_RES_15); // RL9 RL12

   always_ff @(posedge clock)
   begin
      if (reset)
         state_ff <= hldrc_pkg::HLDRC_IDLE;
      else
         unique case (state_ff)
            hldrc_pkg::HLDRC_IDLE:
               if (plug_rise && load_detect_enable) // RL7
                  state_ff <= hldrc_pkg::HLDRC_RES;
            hldrc_pkg::HLDRC_RES:
               if (meas_end)
                  state_ff <= (res_code == `HLDRC_RES_3K) ? // RL10
                     hldrc_pkg::HLDRC_CAP : hldrc_pkg::HLDRC_IDLE;
            hldrc_pkg::HLDRC_CAP:
               if (meas_end)
                  state_ff <= hldrc_pkg::HLDRC_IDLE;
            default:
               state_ff <= hldrc_pkg::HLDRC_IDLE;
         endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset || state_ff == hldrc_pkg::HLDRC_IDLE || meas_end)
         meas_cnt_ff <= 32'h0;
      else
         meas_cnt_ff <= meas_cnt_ff + 32'h1;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         res_ff <= `HLDRC_RES_15;
         cap_ff <= 1'b0;
      end
      else if (state_ff == hldrc_pkg::HLDRC_RES && meas_end)
      begin
         res_ff <= res_code; // RL9
         cap_ff <= 1'b0; // RL10
      end
      else if (state_ff == hldrc_pkg::HLDRC_CAP && meas_end)
         cap_ff <= sync2_ff[3]; // RL11
   end

   // Done clears when a new sequence starts, sets at its end
   always_ff @(posedge clock)
   begin
      if (reset)
         done_ff <= 1'b0;
      else if (meas_end && (state_ff == hldrc_pkg::HLDRC_CAP ||
         res_code != `HLDRC_RES_3K))
         done_ff <= 1'b1; // RL11
      else if (state_ff == hldrc_pkg::HLDRC_IDLE && plug_rise &&
         load_detect_enable)
         done_ff <= 1'b0;
   end

   // Tone only while measuring, so the output idles low
   always_ff @(posedge clock)
   begin
      if (reset || state_ff == hldrc_pkg::HLDRC_IDLE)
      begin
         tone_cnt_ff <= 32'h0;
         tone_ff <= 1'b0;
      end
      else if (tone_cnt_ff == 32'(TONE_HALF - 1))
      begin
         tone_cnt_ff <= 32'h0;
         tone_ff <= !tone_ff; // RL8
      end
      else
         tone_cnt_ff <= tone_cnt_ff + 32'h1;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         sense_ff <= 1'b0;
      else if (state_ff == hldrc_pkg::HLDRC_IDLE)
         sense_ff <= china_headset; // RL8
   end

   assign headphone_out_left = tone_ff;
   assign sense_fourth_select = sense_ff;
   assign measure_active = state_ff != hldrc_pkg::HLDRC_IDLE;
   assign load_resistance_status = res_ff;
   assign load_capacitance_status = cap_ff;
   assign load_detect_done = done_ff;

   // ----------------------------------------
   // Volume ramps
   // ----------------------------------------
   logic ramp_on;
   assign ramp_on = slow_start_select == `HLDRC_SLOW_ON; // RL14

   hldrc_ramp #(.VW(VW)) u_ramp_play (
      .clock(clock),
      .reset(reset),
      .fs_tick(fs_tick),
      .ramp_enable(ramp_on),
      .rate(digital_ramp_rate),
      .target(playback_volume_target),
      .level(playback_volume)
   );

   hldrc_ramp #(.VW(VW)) u_ramp_hp (
      .clock(clock),
      .reset(reset),
      .fs_tick(fs_tick),
      .ramp_enable(ramp_on),
      .rate(analog_ramp_rate),
      .target(headphone_volume_target),
      .level(headphone_volume)
   );

   // ----------------------------------------
   // Rail selection
   // ----------------------------------------
   logic [7:0] thr0;
   logic [7:0] thr1;
   logic [7:0] thr2;
   logic [1:0] demand;
   logic [1:0] rail_ff;
   logic [31:0] hyst_ff;
   logic adapt;
   logic hyst_end;

   // One threshold set serves both channels
   always_comb
   begin
      unique case (res_ff) // RL19 RL12
         `HLDRC_RES_15:
         begin
            thr0 = cap_ff ? `HLDRC_T15H_0 : `HLDRC_T15L_0;
            thr1 = cap_ff ? `HLDRC_T15H_1 : `HLDRC_T15L_1;
            thr2 = cap_ff ? `HLDRC_T15H_2 : `HLDRC_T15L_2;
         end
         `HLDRC_RES_30:
         begin
            thr0 = `HLDRC_T30_0;
            thr1 = `HLDRC_T30_1;
            thr2 = `HLDRC_T30_2;
         end
         default:
         begin
            thr0 = `HLDRC_T3K_0;
            thr1 = `HLDRC_T3K_1;
            thr2 = `HLDRC_T3K_2;
         end
      endcase
   end

   assign demand = (signal_attenuation <= thr0) ? hldrc_pkg::HLDRC_RAIL_2V5 :
      (signal_attenuation <= thr1) ? hldrc_pkg::HLDRC_RAIL_VCP :
      (signal_attenuation <= thr2) ? hldrc_pkg::HLDRC_RAIL_VCP2 :
      hldrc_pkg::HLDRC_RAIL_VCP3; // RL18
   assign adapt = adaptive_power_select == `HLDRC_PWR_ADAPT;
   assign hyst_end = hyst_ff == 32'(HYST_CYCLES - 1);

   // Any demand at or above the present rail restarts the wait
   always_ff @(posedge clock)
   begin
      if (reset || !adapt || demand <= rail_ff || hyst_end)
         hyst_ff <= 32'h0; // RL22
      else
         hyst_ff <= hyst_ff + 32'h1; // RL21
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         rail_ff <= hldrc_pkg::HLDRC_RAIL_2V5;
      else if (adapt)
      begin
         if (demand < rail_ff && pump_flying_tick)
            rail_ff <= demand; // RL20
         else if (demand > rail_ff && hyst_end)
            rail_ff <= demand; // RL21
      end
      else
         unique case (adaptive_power_select) // RL17
            `HLDRC_PWR_FIX1: rail_ff <= hldrc_pkg::HLDRC_RAIL_VCP;
            `HLDRC_PWR_FIX2: rail_ff <= hldrc_pkg::HLDRC_RAIL_VCP2;
            `HLDRC_PWR_FIX3: rail_ff <= hldrc_pkg::HLDRC_RAIL_VCP3;
            default: rail_ff <= hldrc_pkg::HLDRC_RAIL_2V5;
         endcase
   end
   assign rail_level = rail_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   detect_start_a: assert property (@(posedge clock) disable iff (reset)
      state_ff == hldrc_pkg::HLDRC_IDLE && plug_rise && load_detect_enable
      |=> state_ff == hldrc_pkg::HLDRC_RES) // RL7
      else $error("detection did not start");
   detect_gate_a: assert property (@(posedge clock) disable iff (reset)
      state_ff == hldrc_pkg::HLDRC_IDLE && !load_detect_enable
      |=> state_ff == hldrc_pkg::HLDRC_IDLE) // RL7
      else $error("detection started while disabled");
   tone_idle_a: assert property (@(posedge clock) disable iff (reset)
      state_ff == hldrc_pkg::HLDRC_IDLE |=> !tone_ff) // RL8
      else $error("tone outside detection");
   res_code_a: assert property (@(posedge clock) disable iff (reset)
      res_ff != 2'h3) // RL9
      else $error("reserved resistance code");
   low_cap_a: assert property (@(posedge clock) disable iff (reset)
      state_ff == hldrc_pkg::HLDRC_RES && meas_end &&
      res_code != `HLDRC_RES_3K |=> !cap_ff && done_ff &&
      state_ff == hldrc_pkg::HLDRC_IDLE) // RL10
      else $error("low resistance not finished as low capacitance");
   cap_done_a: assert property (@(posedge clock) disable iff (reset)
      state_ff == hldrc_pkg::HLDRC_CAP && meas_end
      |=> done_ff && cap_ff == $past(sync2_ff[3])) // RL11
      else $error("capacitance result not reported");
   fixed_rail_a: assert property (@(posedge clock) disable iff (reset)
      adaptive_power_select == `HLDRC_PWR_FIX3 ##1
      adaptive_power_select == `HLDRC_PWR_FIX3
      |-> rail_ff == hldrc_pkg::HLDRC_RAIL_VCP3) // RL17
      else $error("fixed rail not held");
   rail_up_a: assert property (@(posedge clock) disable iff (reset)
      adapt && demand < rail_ff && pump_flying_tick
      |=> rail_ff == $past(demand)) // RL20
      else $error("rail did not rise on flying clock");
   rail_down_a: assert property (@(posedge clock) disable iff (reset)
      adapt && $past(adapt) && rail_ff > $past(rail_ff)
      |-> $past(hyst_end)) // RL21
      else $error("rail dropped before hysteresis");
   hyst_restart_a: assert property (@(posedge clock) disable iff (reset)
      adapt && demand <= rail_ff |=> hyst_ff == 32'h0) // RL22
      else $error("hysteresis not restarted");
endmodule : hldrc_top

//--- verification/hldrc_load_model.sv
module hldrc_load_model (
   input wire logic plugged,
   input wire logic [1:0] res_code,
   input wire logic cap_high,
   output logic plug_detect_pin,
   output logic res_above_mid_pin,
   output logic res_above_high_pin,
   output logic cap_high_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Load seen by the comparators
   // ----------------------------------------
   assign plug_detect_pin = plugged;
   // Empty jack reads as an open circuit, never as a stale load
   assign res_above_mid_pin = !plugged || (res_code != 2'h0);
   assign res_above_high_pin = !plugged || (res_code == 2'h2);
   assign cap_high_pin = plugged && cap_high;
endmodule : hldrc_load_model

//--- verification/headphone_load_detect_rail_control_tb_top.sv
module headphone_load_detect_rail_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // Long enough for the tone to toggle inside one measurement phase
   localparam int MEAS = 250;
   localparam int HYST = 50;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic fs_tick = 1'b0;
   logic pump_flying_tick = 1'b0;
   logic load_detect_enable = 1'b0;
   logic china_headset = 1'b0;
   logic [2:0] slow_start_select = 3'h0;
   logic [3:0] digital_ramp_rate = 4'h0;
   logic [3:0] analog_ramp_rate = 4'h0;
   logic [7:0] pb_target = 8'h00;
   logic [7:0] hp_target = 8'h00;
   logic [7:0] attenuation = 8'h00;
   logic [2:0] power_select = 3'h1;
   logic plugged = 1'b0;
   logic [1:0] load_res = 2'h0;
   logic load_cap = 1'b0;
   logic plug_pin;
   logic mid_pin;
   logic high_pin;
   logic cap_pin;
   logic tone;
   logic sense4;
   logic meas;
   logic [1:0] res_stat;
   logic cap_stat;
   logic done;
   logic [7:0] pb_vol;
   logic [7:0] hp_vol;
   logic [1:0] rail;
   int err_count = 0;
   int n_checks = 0;

   always #50 clock = ~clock;

   hldrc_load_model load (
      .plugged(plugged), .res_code(load_res), .cap_high(load_cap),
      .plug_detect_pin(plug_pin), .res_above_mid_pin(mid_pin),
      .res_above_high_pin(high_pin), .cap_high_pin(cap_pin)
   );

   hldrc_top #(.VW(8), .MEAS_CYCLES(MEAS), .HYST_CYCLES(HYST)) uut (
      .clock(clock), .reset(reset), .fs_tick(fs_tick),
      .pump_flying_tick(pump_flying_tick), .plug_detect_pin(plug_pin),
      .res_above_mid_pin(mid_pin), .res_above_high_pin(high_pin),
      .cap_high_pin(cap_pin), .load_detect_enable(load_detect_enable),
      .china_headset(china_headset), .slow_start_select(slow_start_select),
      .digital_ramp_rate(digital_ramp_rate),
      .analog_ramp_rate(analog_ramp_rate),
      .playback_volume_target(pb_target),
      .headphone_volume_target(hp_target),
      .signal_attenuation(attenuation),
      .adaptive_power_select(power_select), .headphone_out_left(tone),
      .sense_fourth_select(sense4), .measure_active(meas),
      .load_resistance_status(res_stat), .load_capacitance_status(cap_stat),
      .load_detect_done(done), .playback_volume(pb_vol),
      .headphone_volume(hp_vol), .rail_level(rail)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, seen);
         err_count++;
      end
   endtask : check

   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   task give_up(input string what);
      $display("ERROR %s expected 1 seen timeout", what);
      err_count++;
      wrap_up();
   endtask : give_up

   task cycles(input int n);
      repeat (n) @(negedge clock);
   endtask : cycles

   task fs_pulse;
      fs_tick = 1'b1;
      cycles(1);
      fs_tick = 1'b0;
      cycles(1);
   endtask : fs_pulse

   // Replug so the synchronised plug level shows a fresh rising edge
   task detect(input logic [1:0] r, input logic c, input logic [1:0] er,
      input logic ec);
      int k;
      logic toned;
      plugged = 1'b0;
      cycles(4);
      load_res = r;
      load_cap = c;
      plugged = 1'b1;
      for (k = 0; k < 8 && meas !== 1'b1; k++)
         cycles(1);
      if (meas !== 1'b1)
         give_up("measure start");
      check("done cleared", {7'h00, done}, 8'h00);
      check("tone start", {7'h00, tone}, 8'h00);
      toned = 1'b0;
      for (k = 0; k < 4 * MEAS && done !== 1'b1; k++)
      begin
         cycles(1);
         if (tone === 1'b1)
            toned = 1'b1;
      end
      if (done !== 1'b1)
         give_up("detect done");
      check("resistance", {6'h00, res_stat}, {6'h00, er});
      check("capacitance", {7'h00, cap_stat}, {7'h00, ec});
      check("cap phase", {7'h00, k > MEAS + MEAS / 2},
         {7'h00, er == 2'h2});
      check("measure idle", {7'h00, meas}, 8'h00);
      check("tone seen", {7'h00, toned}, 8'h01);
   endtask : detect

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int k;
      cycles(3);
      reset = 1'b0;
      check("reset rail", {6'h00, rail}, 8'h00);
      check("reset volume", hp_vol, 8'h00);
      check("reset done", {7'h00, done}, 8'h00);
      china_headset = 1'b1;
      cycles(3);
      check("sense select", {7'h00, sense4}, 8'h01);
      plugged = 1'b1;
      cycles(10);
      check("disabled detect", {7'h00, meas}, 8'h00);
      check("disabled done", {7'h00, done}, 8'h00);
      // Power-down, mute and filter sit outside
      load_detect_enable = 1'b1;
      power_select = 3'h4;
      analog_ramp_rate = 4'h7;
      digital_ramp_rate = 4'h1;
      detect(2'h0, 1'b1, 2'h0, 1'b0);
      detect(2'h1, 1'b0, 2'h1, 1'b0);
      detect(2'h2, 1'b0, 2'h2, 1'b0);
      detect(2'h2, 1'b1, 2'h2, 1'b1);
      power_select = 3'h1;
      analog_ramp_rate = 4'h0;
      digital_ramp_rate = 4'h0;
      // Soft ramp, one step per wait
      slow_start_select = 3'h7;
      pb_target = 8'h02;
      hp_target = 8'h02;
      cycles(3);
      check("no tick hold", hp_vol, 8'h00);
      fs_pulse();
      check("hp step 1", hp_vol, 8'h01);
      check("pb step 1", pb_vol, 8'h01);
      fs_pulse();
      check("hp step 2", hp_vol, 8'h02);
      check("pb step 2", pb_vol, 8'h02);
      analog_ramp_rate = 4'h1;
      hp_target = 8'h03;
      fs_pulse();
      check("rate 1 wait", hp_vol, 8'h02);
      fs_pulse();
      check("rate 1 step", hp_vol, 8'h03);
      slow_start_select = 3'h0;
      pb_target = 8'h33;
      hp_target = 8'h5a;
      cycles(1);
      check("pb immediate", pb_vol, 8'h33);
      check("hp immediate", hp_vol, 8'h5a);
      // Fixed rails ignore a quiet signal
      attenuation = 8'h40;
      for (k = 0; k < 7; k++)
      begin
         power_select = k[2:0];
         cycles(2);
         check("fixed rail", {6'h00, rail},
            (k >= 1 && k <= 4) ? 8'(k - 1) : 8'h00);
      end
      power_select = 3'h1;
      cycles(2);
      power_select = 3'h7;
      cycles(HYST - 10);
      check("hysteresis hold", {6'h00, rail}, 8'h00);
      for (k = 0; k < 3 * HYST && rail !== 2'h3; k++)
         cycles(1);
      if (rail !== 2'h3)
         give_up("adaptive low");
      check("adaptive low", {6'h00, rail}, 8'h03);
      attenuation = 8'h00;
      cycles(4);
      check("await flying", {6'h00, rail}, 8'h03);
      pump_flying_tick = 1'b1;
      cycles(1);
      pump_flying_tick = 1'b0;
      check("adaptive high", {6'h00, rail}, 8'h00);
      attenuation = 8'h40;
      cycles(HYST - 10);
      attenuation = 8'h00;
      cycles(2);
      attenuation = 8'h40;
      cycles(HYST - 10);
      check("timer restart", {6'h00, rail}, 8'h00);
      // High-impedance load: 9 dB down only needs the half rail
      attenuation = 8'h09;
      for (k = 0; k < 3 * HYST && rail !== 2'h2; k++)
         cycles(1);
      if (rail !== 2'h2)
         give_up("load threshold");
      check("load threshold", {6'h00, rail}, 8'h02);
      wrap_up();
   end
endmodule : headphone_load_detect_rail_control_tb_top
